/* shared/bccs_map.svh */
`ifndef BCCS_MAP_SVH
`define BCCS_MAP_SVH
// ****************************************
// configuration offsets (byte addresses)
// ****************************************
`define BCCS_OFF_ID 8'h00
`define BCCS_OFF_CMD 8'h04
`define BCCS_OFF_STATUS 8'h06
`define BCCS_OFF_BAR 8'h10
`define BCCS_OFF_CAPPTR 8'h34
`define BCCS_OFF_WIN_BASE 8'h40
`define BCCS_OFF_WIN_LIMIT 8'h44
`define BCCS_OFF_MEMTOP 8'h48
`define BCCS_OFF_POLICY 8'h4C
`define BCCS_CAP_OFF 8'hA0
`define BCCS_CAP_STAT_REL 8'h04
`define BCCS_CAP_CMD_REL 8'h08
// ****************************************
// fields and constants
// ****************************************
`define BCCS_STATUS_CAPLIST_BIT 4
`define BCCS_CAPABILITY_IDENTIFIER_GP 8'h02
`define BCCS_NEXT_NULL 8'h00
`define BCCS_ALL_ONES 32'hFFFF_FFFF
`define BCCS_CMD_WMASK 16'h0006
`define BCCS_CMD_MEM_EN_BIT 1
`define BCCS_GPCMD_WMASK 32'h0000_0307
`define BCCS_GPCMD_EN_BIT 8
`define BCCS_GPCMD_SBA_BIT 9
`define BCCS_CFGADDR_WMASK 32'h80FF_FFFC
`define BCCS_CFGADDR_EN_BIT 31
`define BCCS_POLICY_CLAIM_BIT 0
`define BCCS_IO_CFGADDR 16'h0CF8
`define BCCS_IO_CFGDATA 16'h0CFC
// ****************************************
// reset values
// ****************************************
`define BCCS_RST_ZERO32 32'h0000_0000
`define BCCS_RST_CMD 16'h0000
`define BCCS_RST_MEMTOP 32'h0000_0000
// ****************************************
// bus command encodings
// ****************************************
`define BCCS_C_INTACK 4'h0
`define BCCS_C_SPECIAL 4'h1
`define BCCS_C_IORD 4'h2
`define BCCS_C_IOWR 4'h3
`define BCCS_C_MEMRD 4'h6
`define BCCS_C_MEMWR 4'h7
`define BCCS_C_CFGRD 4'hA
`define BCCS_C_CFGWR 4'hB
`define BCCS_C_MEMRDM 4'hC
`define BCCS_C_MEMRDL 4'hE
`define BCCS_C_MEMWRI 4'hF
`endif

/* shared/bccs_pkg.sv */
package bccs_pkg;
  typedef enum logic [2:0] {path_cpu_pci, path_cpu_mem, path_pci_mem, path_cpu_p2p,
    path_gp_mem, path_pci_gp, path_gp_pci, path_gp_queue} bccs_path_type;
  typedef enum logic [1:0] {ans_accept, ans_abort, ans_claim} bccs_ans_type;
  typedef enum logic [2:0] {dest_mem, dest_pci, dest_p2p, dest_self, dest_none} bccs_dest_type;
  typedef enum logic [1:0] {cpu_mem, cpu_io, cpu_intack, cpu_special} bccs_kind_type;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bccs_cfg_type;
  typedef struct packed {
    bccs_path_type path;
    logic [3:0] cmd;
  } bccs_tgt_type;
  typedef struct packed {
    bccs_kind_type kind;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bccs_cpu_type;
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [7:0] len;
  } bccs_gp_type;
endpackage : bccs_pkg

/* verilog/bccs_cmd_check.sv */
`timescale 1ns/10ps
`include "bccs_map.svh"
module bccs_cmd_check (
  input bccs_pkg::bccs_tgt_type req,
  input logic [7:0] opt_en,
  output logic accept,
  output logic is_read
);
  import bccs_pkg::*;
  wire c_io = (req.cmd == `BCCS_C_IORD) || (req.cmd == `BCCS_C_IOWR);
  wire c_cfg = (req.cmd == `BCCS_C_CFGRD) || (req.cmd == `BCCS_C_CFGWR);
  wire c_mrd = (req.cmd == `BCCS_C_MEMRD) || (req.cmd == `BCCS_C_MEMRDL) ||
    (req.cmd == `BCCS_C_MEMRDM);
  wire c_mwr = (req.cmd == `BCCS_C_MEMWR) || (req.cmd == `BCCS_C_MEMWRI);
  wire c_spc = (req.cmd == `BCCS_C_INTACK) || (req.cmd == `BCCS_C_SPECIAL);
  wire p_cpu = (req.path == path_cpu_pci) || (req.path == path_cpu_p2p);
  wire p_mem = (req.path == path_pci_mem) || (req.path == path_gp_mem);
  wire need_gp = (req.path == path_pci_gp) && c_mwr;
  wire need_q = (req.path == path_gp_queue);
  wire usual = (p_cpu && (c_mrd || c_mwr || c_io)) || (p_mem && (c_mrd || c_mwr)) ||
    ((req.path == path_cpu_mem) && (c_mrd || c_mwr));
  wire optional = ((req.path == path_pci_gp) && (c_io || c_cfg || c_mrd)) ||
    ((req.path == path_gp_pci) && (c_io || c_cfg || c_mrd || c_mwr)) ||
    ((req.path == path_pci_mem) && (c_io || c_cfg)) ||
    ((req.path == path_cpu_pci) && c_spc);
  assign accept = need_gp || need_q || usual || (optional && opt_en[req.path]);
  assign is_read = ~req.cmd[0] && (req.cmd != `BCCS_C_INTACK);
endmodule : bccs_cmd_check

/* verilog/bccs_route.sv */
`timescale 1ns/10ps
`include "bccs_map.svh"
module bccs_route (
  input bccs_pkg::bccs_cpu_type req,
  input logic [31:0] memtop,
  input logic [31:0] win_base,
  input logic [31:0] win_limit,
  input logic [31:0] remap_base,
  input logic [31:0] remap_mask,
  input logic remap_on,
  input logic cfg_on,
  input logic spc_en,
  output bccs_pkg::bccs_dest_type dest,
  output logic cfg_conv
);
  import bccs_pkg::*;
  wire in_win = (req.addr >= win_base) && (req.addr <= win_limit);
  wire in_remap = remap_on && ((req.addr & remap_mask) == remap_base);
  wire below_top = req.addr < memtop;
  wire io_addr = (req.addr[15:0] == `BCCS_IO_CFGADDR);
  wire io_data = (req.addr[15:2] == 14'(`BCCS_IO_CFGDATA >> 2));
  wire is_io = (req.kind == cpu_io);
  wire is_mem = (req.kind == cpu_mem);
  // data port becomes a config cycle
  assign cfg_conv = is_io && io_data && cfg_on;
  assign dest = is_mem ? (in_win ? dest_p2p : ((below_top || in_remap) ? dest_mem : dest_pci)) :
    is_io ? (io_addr ? dest_self : dest_pci) :
    (spc_en ? dest_pci : dest_none);
endmodule : bccs_route

/* verilog/bccs_config_space.sv */
`timescale 1ns/10ps
`include "bccs_map.svh"
// Notes on behaviour
// - memory write and memory write and invalidate from pci to graphics target always accepted
// - other pci-to-graphics commands accepted only when policy enables them
// - graphics master to pci: nothing required, optional set gated by policy
// - pci to memory: reads and writes handled, io and config optional
// - processor io to data port turns into a config cycle
// - interrupt acknowledge and special cycles optional on processor path
// - unsupported: master abort, or claim with all ones and dropped writes
// - remap table base register requests a naturally aligned block
// - processor requests steered to memory, pci, bridge-to-bridge function or the address port held inside the bridge
// - registers hold remap table and graphics circuitry settings
// - status bit 4 at byte 6 reads one and is read only
// - offset 34h bits 7:0 give first capability offset, read only
// - capability pointer bits 31:8 read zero, writes ignored
// - graphics status and command reachable through the list
// - capability registers present so software can set transfers
// - first entry location is a parameter, not fixed to graphics entry
// - graphics queue takes commands and hands them to memory controller
// - entry first byte holds identifier 02h
// - next pointer of the last entry is zero
module bccs_config_space #(
  parameter logic [15:0] VENDOR_CODE = 16'h0F0F,
  parameter logic [15:0] DEVICE_CODE = 16'h00F0,
  parameter logic [7:0] CAP_OFF = `BCCS_CAP_OFF,
  parameter int REMAP_LOG2 = 22,
  parameter logic [3:0] CAP_MAJOR = 4'h1,
  parameter logic [3:0] CAP_MINOR = 4'h0,
  parameter logic [7:0] RQ_DEPTH = 8'h0F,
  parameter logic SBA_CAPABLE = 1'b1,
  parameter logic [2:0] RATE_CAPABLE = 3'h3
) (
  input logic clk_sys,
  input logic arst_n,
  input logic cfg_req,
  input bccs_pkg::bccs_cfg_type cfg_acc,
  output logic cfg_ack_r,
  output logic [31:0] cfg_rdata_r,
  input logic tgt_valid,
  input bccs_pkg::bccs_tgt_type tgt_req,
  output logic tgt_done_r,
  output bccs_pkg::bccs_ans_type tgt_ans_r,
  output logic [31:0] tgt_rdata_r,
  input logic cpu_valid,
  input bccs_pkg::bccs_cpu_type cpu_req,
  output logic rte_valid_r,
  output bccs_pkg::bccs_dest_type rte_dest_r,
  output logic rte_cfg_r,
  output logic [31:0] rte_addr_r,
  output logic [31:0] rte_rdata_r,
  input logic gp_valid,
  input bccs_pkg::bccs_gp_type gp_req,
  output logic gp_ready_r,
  output logic mc_valid_r,
  output bccs_pkg::bccs_gp_type mc_req_r,
  input logic mc_ready,
  output logic [31:0] remap_base_r,
  output logic gp_en_r,
  output logic gp_sba_en_r,
  output logic [2:0] gp_rate_r
);
  import bccs_pkg::*;

  // ****************************************
  // byte-enable merge
  // ****************************************
  function automatic logic [31:0] bccs_merge(input logic [31:0] old, input logic [31:0] wd,
      input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] lane;
    lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~lane) | (wd & lane);
  endfunction : bccs_merge

  // ****************************************
  // register state
  // ****************************************
  logic [15:0] cmd_r;
  logic [31:0] bar_r;
  logic [31:0] win_base_r;
  logic [31:0] win_limit_r;
  logic [31:0] memtop_r;
  logic [31:0] policy_r;
  logic [31:0] gpcmd_r;
  logic [31:0] cfgaddr_r;
  logic q_full_r;

  // ****************************************
  // fixed capability content
  // ****************************************
  localparam logic [31:0] BAR_MASK = ~((32'h1 << REMAP_LOG2) - 32'h1);
  localparam logic [7:0] CAP_STAT = 8'(CAP_OFF + `BCCS_CAP_STAT_REL);
  localparam logic [7:0] CAP_CMD = 8'(CAP_OFF + `BCCS_CAP_CMD_REL);
  localparam logic CAP_PRESENT = (CAP_OFF != 8'h00);
  localparam logic [31:0] PTR_WORD = {24'h000000, CAP_OFF};
  localparam logic [31:0] CAP_HEAD = {8'h00, CAP_MAJOR, CAP_MINOR, `BCCS_NEXT_NULL,
    `BCCS_CAPABILITY_IDENTIFIER_GP};
  localparam logic [31:0] CAP_STAT_WORD = {RQ_DEPTH, 14'h0000, SBA_CAPABLE, 6'h00,
    RATE_CAPABLE};

  // ****************************************
  // configuration decode
  // ****************************************
  wire [7:0] cfg_dw = {cfg_acc.addr[7:2], 2'b00};
  wire cfg_wr = cfg_req && cfg_acc.we;
  wire hit_id = (cfg_dw == `BCCS_OFF_ID);
  wire hit_cmd = (cfg_dw == `BCCS_OFF_CMD);
  wire hit_bar = (cfg_dw == `BCCS_OFF_BAR);
  wire hit_ptr = (cfg_dw == `BCCS_OFF_CAPPTR);
  wire hit_wb = (cfg_dw == `BCCS_OFF_WIN_BASE);
  wire hit_wl = (cfg_dw == `BCCS_OFF_WIN_LIMIT);
  wire hit_top = (cfg_dw == `BCCS_OFF_MEMTOP);
  wire hit_pol = (cfg_dw == `BCCS_OFF_POLICY);
  wire hit_cap = CAP_PRESENT && (cfg_dw == CAP_OFF);
  wire hit_cst = CAP_PRESENT && (cfg_dw == CAP_STAT);
  wire hit_ccm = CAP_PRESENT && (cfg_dw == CAP_CMD);

  // ****************************************
  // status word and read select
  // ****************************************
  // status half of the word at 04h
  wire [15:0] status_word = 16'h0000 | (16'(CAP_PRESENT) << `BCCS_STATUS_CAPLIST_BIT);
  wire [31:0] rd_word =
    hit_id ? {DEVICE_CODE, VENDOR_CODE} :
    hit_cmd ? {status_word, cmd_r} :
    hit_bar ? bar_r :
    hit_ptr ? PTR_WORD :
    hit_wb ? win_base_r :
    hit_wl ? win_limit_r :
    hit_top ? memtop_r :
    hit_pol ? policy_r :
    hit_cap ? CAP_HEAD :
    hit_cst ? CAP_STAT_WORD :
    hit_ccm ? gpcmd_r :
    32'h0000_0000;

  // ****************************************
  // write next values
  // ****************************************
  // only the command half is writable
  wire [31:0] cmd_m = bccs_merge({16'h0000, cmd_r}, cfg_acc.wdata, cfg_acc.be,
    {16'h0000, `BCCS_CMD_WMASK});
  wire [15:0] cmd_nxt = (cfg_wr && hit_cmd) ? cmd_m[15:0] : cmd_r;
  // low bits stay zero for alignment
  wire [31:0] bar_nxt = (cfg_wr && hit_bar) ?
    bccs_merge(bar_r, cfg_acc.wdata, cfg_acc.be, BAR_MASK) : bar_r;

  // ****************************************
  // window, top, policy and graphics command registers
  // ****************************************
  // routing, policy and graphics command settings
  wire [31:0] wb_nxt = (cfg_wr && hit_wb) ?
    bccs_merge(win_base_r, cfg_acc.wdata, cfg_acc.be, `BCCS_ALL_ONES) : win_base_r;
  wire [31:0] wl_nxt = (cfg_wr && hit_wl) ?
    bccs_merge(win_limit_r, cfg_acc.wdata, cfg_acc.be, `BCCS_ALL_ONES) : win_limit_r;
  wire [31:0] top_nxt = (cfg_wr && hit_top) ?
    bccs_merge(memtop_r, cfg_acc.wdata, cfg_acc.be, `BCCS_ALL_ONES) : memtop_r;
  wire [31:0] pol_nxt = (cfg_wr && hit_pol) ?
    bccs_merge(policy_r, cfg_acc.wdata, cfg_acc.be, 32'h0000_FF01) : policy_r;
  wire [31:0] gpcmd_nxt = (cfg_wr && hit_ccm) ?
    bccs_merge(gpcmd_r, cfg_acc.wdata, cfg_acc.be, `BCCS_GPCMD_WMASK) : gpcmd_r;

  // ****************************************
  // register update
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_r <= `BCCS_RST_CMD;
      bar_r <= `BCCS_RST_ZERO32;
      win_base_r <= `BCCS_ALL_ONES;
      win_limit_r <= `BCCS_RST_ZERO32;
      memtop_r <= `BCCS_RST_MEMTOP;
      policy_r <= `BCCS_RST_ZERO32;
      gpcmd_r <= `BCCS_RST_ZERO32;
    end else begin
      cmd_r <= cmd_nxt;
      bar_r <= bar_nxt;
      win_base_r <= wb_nxt;
      win_limit_r <= wl_nxt;
      memtop_r <= top_nxt;
      policy_r <= pol_nxt;
      gpcmd_r <= gpcmd_nxt;
    end
  end

  // ****************************************
  // configuration answer
  // ****************************************
  // pointer has no write path
  wire cfg_rd = cfg_req && !cfg_acc.we;
  wire [31:0] cfg_rdata_nxt = cfg_rd ? rd_word : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ack_r <= 1'b0;
      cfg_rdata_r <= 32'h0000_0000;
    end else begin
      cfg_ack_r <= cfg_req;
      cfg_rdata_r <= cfg_rdata_nxt;
    end
  end

  // ****************************************
  // command acceptance
  // ****************************************
  logic tgt_accept;
  logic tgt_is_read;

  bccs_cmd_check u_check (
    .req(tgt_req),
    .opt_en(policy_r[15:8]),
    .accept(tgt_accept),
    .is_read(tgt_is_read)
  );

  // ****************************************
  // unsupported command answer
  // ****************************************
  wire claim_en = policy_r[`BCCS_POLICY_CLAIM_BIT];
  wire bccs_ans_type tgt_ans_nxt = tgt_accept ? ans_accept :
    (claim_en ? ans_claim : ans_abort);
  wire [31:0] tgt_rdata_nxt = (tgt_valid && !tgt_accept && claim_en && tgt_is_read) ?
    `BCCS_ALL_ONES : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tgt_done_r <= 1'b0;
      tgt_ans_r <= ans_abort;
      tgt_rdata_r <= 32'h0000_0000;
    end else begin
      tgt_done_r <= tgt_valid;
      tgt_ans_r <= tgt_valid ? tgt_ans_nxt : tgt_ans_r;
      tgt_rdata_r <= tgt_rdata_nxt;
    end
  end

  // ****************************************
  // processor routing
  // ****************************************
  bccs_dest_type cpu_dest;
  logic cpu_cfg;

  bccs_route u_route (
    .req(cpu_req),
    .memtop(memtop_r),
    .win_base(win_base_r),
    .win_limit(win_limit_r),
    .remap_base(bar_r),
    .remap_mask(BAR_MASK),
    .remap_on(cmd_r[`BCCS_CMD_MEM_EN_BIT]),
    .cfg_on(cfgaddr_r[`BCCS_CFGADDR_EN_BIT]),
    .spc_en(policy_r[8]),
    .dest(cpu_dest),
    .cfg_conv(cpu_cfg)
  );

  // ****************************************
  // address port and conversion
  // ****************************************
  // address port held inside the bridge
  wire self_wr = cpu_valid && (cpu_dest == dest_self) && cpu_req.we;
  wire self_rd = cpu_valid && (cpu_dest == dest_self) && !cpu_req.we;
  wire [31:0] cfgaddr_nxt = self_wr ?
    (cpu_req.wdata & `BCCS_CFGADDR_WMASK) : cfgaddr_r;
  // converted cycle carries the held address
  wire [31:0] rte_addr_nxt = cpu_cfg ? {cfgaddr_r[31:2], cpu_req.addr[1:0]} : cpu_req.addr;
  wire [31:0] rte_rdata_nxt = self_rd ? cfgaddr_r : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfgaddr_r <= `BCCS_RST_ZERO32;
      rte_valid_r <= 1'b0;
      rte_dest_r <= dest_none;
      rte_cfg_r <= 1'b0;
      rte_addr_r <= 32'h0000_0000;
      rte_rdata_r <= 32'h0000_0000;
    end else begin
      cfgaddr_r <= cfgaddr_nxt;
      rte_valid_r <= cpu_valid;
      rte_dest_r <= cpu_valid ? cpu_dest : rte_dest_r;
      rte_cfg_r <= cpu_valid && cpu_cfg;
      rte_addr_r <= cpu_valid ? rte_addr_nxt : rte_addr_r;
      rte_rdata_r <= rte_rdata_nxt;
    end
  end

  // ****************************************
  // graphics request slot
  // ****************************************
  // single slot toward memory controller
  wire gp_take = gp_valid && gp_ready_r;
  wire q_full_nxt = (q_full_r && !mc_ready) || gp_take;
  wire gp_slot_en = gpcmd_r[`BCCS_GPCMD_EN_BIT];
  wire gp_ready_nxt = !q_full_nxt && gp_slot_en;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q_full_r <= 1'b0;
      gp_ready_r <= 1'b0;
      mc_valid_r <= 1'b0;
      mc_req_r <= '0;
    end else begin
      q_full_r <= q_full_nxt;
      gp_ready_r <= gp_ready_nxt;
      mc_valid_r <= q_full_nxt;
      mc_req_r <= gp_take ? gp_req : mc_req_r;
    end
  end

  // ****************************************
  // settings to interface circuitry
  // ****************************************
  wire [31:0] remap_base_nxt = bar_nxt;
  wire gp_en_nxt = gpcmd_nxt[`BCCS_GPCMD_EN_BIT];
  wire gp_sba_en_nxt = gpcmd_nxt[`BCCS_GPCMD_SBA_BIT];
  wire [2:0] gp_rate_nxt = gpcmd_nxt[2:0];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      remap_base_r <= 32'h0000_0000;
      gp_en_r <= 1'b0;
      gp_sba_en_r <= 1'b0;
      gp_rate_r <= 3'h0;
    end else begin
      remap_base_r <= remap_base_nxt;
      gp_en_r <= gp_en_nxt;
      gp_sba_en_r <= gp_sba_en_nxt;
      gp_rate_r <= gp_rate_nxt;
    end
  end

endmodule : bccs_config_space

/* tb/bccs_mc_model.sv */
`timescale 1ns/10ps
module bccs_mc_model (
  input logic clk_sys,
  input logic arst_n,
  input logic mc_valid_r,
  input bccs_pkg::bccs_gp_type mc_req_r,
  input logic slow,
  output logic mc_ready,
  output int taken,
  output logic [31:0] last_addr
);
  import bccs_pkg::*;
  logic [1:0] wait_r;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 2'h0;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
  assign mc_ready = mc_valid_r && (!slow || wait_r == 2'h3);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      taken <= 0;
      last_addr <= 32'h0000_0000;
    end else if (mc_valid_r && mc_ready) begin
      taken <= taken + 1;
      last_addr <= mc_req_r.addr;
    end
  end
endmodule : bccs_mc_model

/* tb/bccs_config_space_properties.sv */
`timescale 1ns/10ps
module bccs_config_space_properties #(
  parameter logic [7:0] CAP_OFF = 8'hA0
) (
  input logic clk_sys,
  input logic arst_n,
  input logic cfg_req,
  input bccs_pkg::bccs_cfg_type cfg_acc,
  input logic cfg_ack_r,
  input logic [31:0] cfg_rdata_r,
  input logic tgt_valid,
  input bccs_pkg::bccs_tgt_type tgt_req,
  input logic tgt_done_r,
  input bccs_pkg::bccs_ans_type tgt_ans_r,
  input logic [31:0] tgt_rdata_r,
  input logic cpu_valid,
  input logic rte_valid_r,
  input logic gp_valid,
  input bccs_pkg::bccs_gp_type gp_req,
  input logic gp_ready_r,
  input logic mc_valid_r,
  input bccs_pkg::bccs_gp_type mc_req_r,
  input logic mc_ready
);
  import bccs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire rd_acc = cfg_req && !cfg_acc.we;
  wire cap_rd = rd_acc && cfg_acc.addr[7:2] == CAP_OFF[7:2];
  wire mwr_gp = tgt_valid && tgt_req.path == path_pci_gp &&
    (tgt_req.cmd == 4'h7 || tgt_req.cmd == 4'hF);
  // ****************************************
  // assertions
  // ****************************************
  cfg_ack_a: assert property (cfg_req |=> cfg_ack_r)
    else $error("config access not acknowledged");
  ptr_read_a: assert property (rd_acc && cfg_acc.addr[7:2] == 6'h0D |=>
    cfg_rdata_r == {24'h000000, CAP_OFF})
    else $error("capability pointer read wrong");
  status_bit_a: assert property (rd_acc && cfg_acc.addr[7:2] == 6'h01 |=>
    cfg_rdata_r[20])
    else $error("list present bit not set");
  cap_entry_a: assert property (cap_rd |=> cfg_rdata_r[7:0] == 8'h02 &&
    cfg_rdata_r[31:24] == 8'h00 && cfg_rdata_r[15:8] == 8'h00)
    else $error("capability entry wrong");
  tgt_done_a: assert property (tgt_valid |=> tgt_done_r)
    else $error("target answer missing");
  mwr_accept_a: assert property (mwr_gp |=> tgt_ans_r == ans_accept)
    else $error("memory write to graphics target refused");
  queue_accept_a: assert property (tgt_valid && tgt_req.path == path_gp_queue |=>
    tgt_ans_r == ans_accept)
    else $error("queue command refused");
  no_claim_data_a: assert property (tgt_done_r && tgt_ans_r != ans_claim |->
    tgt_rdata_r == 32'h0000_0000)
    else $error("read data without claim");
  gp_take_a: assert property (gp_valid && gp_ready_r |=> mc_valid_r && !gp_ready_r &&
    mc_req_r == $past(gp_req))
    else $error("queue request not forwarded");
  mc_hold_a: assert property (mc_valid_r && !mc_ready |=>
    mc_valid_r && $stable(mc_req_r))
    else $error("memory request dropped");
  route_out_a: assert property (cpu_valid |=> rte_valid_r)
    else $error("processor request not routed");
  cover property (cap_rd);
  cover property (tgt_done_r && tgt_ans_r == ans_claim);
  cover property (mc_valid_r && !mc_ready ##1 mc_ready);
endmodule : bccs_config_space_properties
bind bccs_config_space bccs_config_space_properties #(.CAP_OFF(CAP_OFF)) props_u (.clk_sys,
  .arst_n, .cfg_req, .cfg_acc, .cfg_ack_r, .cfg_rdata_r, .tgt_valid, .tgt_req, .tgt_done_r,
  .tgt_ans_r, .tgt_rdata_r, .cpu_valid, .rte_valid_r, .gp_valid, .gp_req, .gp_ready_r,
  .mc_valid_r, .mc_req_r, .mc_ready);

/* tb/bccs_config_space_test.sv */
`timescale 1ns/10ps
module bccs_config_space_test;
  import bccs_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n, cfg_req, cfg_ack_r, tgt_valid, tgt_done_r, cpu_valid, rte_valid_r, rte_cfg_r;
  logic gp_valid, gp_ready_r, mc_valid_r, mc_ready, gp_en_r, gp_sba_en_r, slow;
  logic [2:0] gp_rate_r;
  logic [31:0] cfg_rdata_r, tgt_rdata_r, rte_addr_r, rte_rdata_r, remap_base_r, last_addr, rd;
  bccs_cfg_type cfg_acc;
  bccs_tgt_type tgt_req;
  bccs_ans_type tgt_ans_r;
  bccs_cpu_type cpu_req;
  bccs_dest_type rte_dest_r;
  bccs_gp_type gp_req, mc_req_r;
  int miscompares = 0, samples_checked = 0, taken, n;
  always #4 clk_sys = ~clk_sys;
  bccs_config_space #(.REMAP_LOG2(22)) dut_u (.clk_sys, .arst_n, .cfg_req, .cfg_acc,
    .cfg_ack_r, .cfg_rdata_r, .tgt_valid, .tgt_req, .tgt_done_r, .tgt_ans_r, .tgt_rdata_r,
    .cpu_valid, .cpu_req, .rte_valid_r, .rte_dest_r, .rte_cfg_r, .rte_addr_r, .rte_rdata_r,
    .gp_valid, .gp_req, .gp_ready_r, .mc_valid_r, .mc_req_r, .mc_ready, .remap_base_r,
    .gp_en_r, .gp_sba_en_r, .gp_rate_r);
  bccs_mc_model mc_u (.clk_sys, .arst_n, .mc_valid_r, .mc_req_r, .slow, .mc_ready, .taken,
    .last_addr);
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cfg(input logic we, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys); #1;
    cfg_req = 1'b1;
    cfg_acc = '{we, a, 4'hF, wd};
    @(posedge clk_sys); #1;
    cfg_req = 1'b0;
    chk("cfg_ack_r", {31'h0, cfg_ack_r}, 32'h1);
    rd = cfg_rdata_r;
  endtask : cfg
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 32'h0);
    chk($sformatf("cfg_rdata_r at %h", a), rd, exp);
  endtask : rdchk
  task automatic tgt(input bccs_path_type p, input logic [3:0] c, input bccs_ans_type ea,
    input logic [31:0] ed);
    @(posedge clk_sys); #1;
    tgt_valid = 1'b1;
    tgt_req = '{p, c};
    @(posedge clk_sys); #1;
    tgt_valid = 1'b0;
    chk("tgt_done_r", {31'h0, tgt_done_r}, 32'h1);
    chk($sformatf("tgt_ans_r path %0d cmd %h", p, c), {30'h0, tgt_ans_r}, {30'h0, ea});
    chk("tgt_rdata_r", tgt_rdata_r, ed);
  endtask : tgt
  task automatic cpu(input bccs_kind_type k, input logic we, input logic [31:0] a,
    input logic [31:0] wd, input bccs_dest_type ed, input logic ec, input logic [31:0] er);
    @(posedge clk_sys); #1;
    cpu_valid = 1'b1;
    cpu_req = '{k, we, a, wd};
    @(posedge clk_sys); #1;
    cpu_valid = 1'b0;
    chk("rte_valid_r", {31'h0, rte_valid_r}, 32'h1);
    chk($sformatf("rte_dest_r addr %h", a), {29'h0, rte_dest_r}, {29'h0, ed});
    chk("rte_cfg_r", {31'h0, rte_cfg_r}, {31'h0, ec});
    chk("rte_rdata_r", rte_rdata_r, er);
  endtask : cpu
  task automatic gp_send(input logic [31:0] a);
    gp_valid = 1'b1;
    gp_req = '{1'b0, a, 8'h03};
    n = 0;
    while (gp_ready_r !== 1'b1 && n < 50) begin
      @(posedge clk_sys); #1;
      n++;
    end
    @(posedge clk_sys); #1;
  endtask : gp_send
  // ****************************************
  // scenarios
  // ****************************************
  task automatic reg_test;
    chk("gp_ready_r", {31'h0, gp_ready_r}, 32'h0);
    rdchk(8'h04, 32'h0010_0000);
    cfg(1'b1, 8'h04, 32'hFFFF_FFFF);
    rdchk(8'h04, 32'h0010_0006);
    cfg(1'b1, 8'h34, 32'hFFFF_FFFF);
    rdchk(8'h34, 32'h0000_00A0);
    rdchk(8'hA0, 32'h0010_0002);
    rdchk(8'hA4, 32'h0F00_0203);
    cfg(1'b1, 8'h10, 32'hFFFF_FFFF);
    rdchk(8'h10, 32'hFFC0_0000);
    chk("remap_base_r", remap_base_r, 32'hFFC0_0000);
    cfg(1'b1, 8'hA8, 32'hFFFF_FFFF);
    rdchk(8'hA8, 32'h0000_0307);
    chk("gp controls", {27'h0, gp_sba_en_r, gp_en_r, gp_rate_r}, 32'h1F);
    chk("gp_ready_r", {31'h0, gp_ready_r}, 32'h1);
    rdchk(8'hF0, 32'h0000_0000);
  endtask : reg_test
  task automatic tgt_test;
    logic [3:0] mcmd[5] = '{4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
    tgt(path_pci_gp, 4'h7, ans_accept, 32'h0);
    tgt(path_pci_gp, 4'hF, ans_accept, 32'h0);
    tgt(path_pci_gp, 4'h6, ans_abort, 32'h0);
    tgt(path_gp_pci, 4'h7, ans_abort, 32'h0);
    foreach (mcmd[i]) tgt(path_pci_mem, mcmd[i], ans_accept, 32'h0);
    tgt(path_pci_mem, 4'h2, ans_abort, 32'h0);
    tgt(path_cpu_pci, 4'h0, ans_abort, 32'h0);
    cpu(cpu_special, 1'b0, 32'h0, 32'h0, dest_none, 1'b0, 32'h0);
    tgt(path_gp_queue, 4'h3, ans_accept, 32'h0);
    cfg(1'b1, 8'h4C, 32'h0000_2101);
    tgt(path_pci_gp, 4'h6, ans_accept, 32'h0);
    tgt(path_gp_pci, 4'h6, ans_claim, 32'hFFFF_FFFF);
    tgt(path_gp_pci, 4'h7, ans_claim, 32'h0);
    tgt(path_pci_mem, 4'h2, ans_claim, 32'hFFFF_FFFF);
    tgt(path_cpu_pci, 4'h1, ans_accept, 32'h0);
  endtask : tgt_test
  task automatic cpu_test;
    cfg(1'b1, 8'h48, 32'h1000_0000);
    cfg(1'b1, 8'h40, 32'h3000_0000);
    cfg(1'b1, 8'h44, 32'h3FFF_FFFF);
    cpu(cpu_mem, 1'b0, 32'h0000_1000, 32'h0, dest_mem, 1'b0, 32'h0);
    cpu(cpu_mem, 1'b0, 32'h2000_0000, 32'h0, dest_pci, 1'b0, 32'h0);
    cpu(cpu_mem, 1'b1, 32'hFFC0_0100, 32'h5, dest_mem, 1'b0, 32'h0);
    cpu(cpu_mem, 1'b0, 32'h3000_0010, 32'h0, dest_p2p, 1'b0, 32'h0);
    cpu(cpu_io, 1'b1, 32'h0000_0CF8, 32'h8000_1237, dest_self, 1'b0, 32'h0);
    cpu(cpu_io, 1'b0, 32'h0000_0CF8, 32'h0, dest_self, 1'b0, 32'h8000_1234);
    cpu(cpu_io, 1'b0, 32'h0000_0CFD, 32'h0, dest_pci, 1'b1, 32'h0);
    chk("rte_addr_r", rte_addr_r, 32'h8000_1235);
    cpu(cpu_io, 1'b0, 32'h0000_0080, 32'h0, dest_pci, 1'b0, 32'h0);
    cpu(cpu_intack, 1'b0, 32'h0, 32'h0, dest_pci, 1'b0, 32'h0);
  endtask : cpu_test
  task automatic gp_test;
    slow = 1'b1;
    gp_send(32'h0000_0100);
    gp_send(32'h0000_0200);
    gp_valid = 1'b0;
    n = 0;
    while (taken < 2 && n < 50) begin
      @(posedge clk_sys); #1;
      n++;
    end
    chk("taken", taken, 2);
    chk("last_addr", last_addr, 32'h0000_0200);
  endtask : gp_test
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
  initial begin
    arst_n = 1'b0;
    cfg_req = 1'b0;
    cfg_acc = '0;
    tgt_valid = 1'b0;
    tgt_req = '0;
    cpu_valid = 1'b0;
    cpu_req = '0;
    gp_valid = 1'b0;
    gp_req = '0;
    slow = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    reg_test();
    tgt_test();
    cpu_test();
    gp_test();
    stop_test();
  end
endmodule : bccs_config_space_test
